// *** src/delay_step_program_port.sv ***
`timescale 1ns/1ns
// Function
// - Mode pin high parallel, low serial
// - Host holds parallel bits in register
// - Wait enable settle time after update
// - Serial bit per shift clock rise, MSB first
// - Eight bits per device per window
// - Seven more clocks read remaining bits
// - Read is destructive; write value back; serial read shifts in cmdCode instead
// - Keep delayed input idle before updates
module delay_step_program_port
    import delay_prog_pkg::*;
#(
    parameter int IDLE_CYCLES = IDLE_CYC    // Idle hold before an update
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    // User side
    input  wire logic              cmdValid,
    output logic                   cmdReady,
    input  wire logic [1:0]        cmdOp,
    input  wire logic [CODE_W-1:0] cmdCode,
    output logic                   rspValid,
    output logic [CODE_W-1:0]      rspCode,
    // Device pins
    output logic                   loadMethodSelect,
    output logic                   addressEnable,
    output logic [CODE_W-1:0]      parallelStepBits,
    output logic                   serialShiftClock,
    output logic                   serialDataIn,
    input  wire logic              serialDataOut,
    output logic                   signalIdle
);
    typedef enum logic [3:0] {
        S_IDLE   = 4'h0,
        S_QUIET  = 4'h1,
        S_PSET   = 4'h2,
        S_PSETTL = 4'h3,
        S_EN_HI  = 4'h4,
        S_EN_LO  = 4'h5,
        S_SFIRST = 4'h6,
        S_CLK_LO = 4'h7,
        S_CLK_HI = 4'h8,
        S_SDROP  = 4'h9,
        S_DONE   = 4'ha
    } state_t;

    state_t              state_reg;    // Sequencer state
    cmd_t                op_reg;       // Command in flight
    logic [CODE_W-1:0]   code_reg;     // Code to write, shifted out MSB first
    logic [CODE_W-1:0]   read_reg;     // Bits gathered from serial out
    logic [3:0]          bitCount_reg; // Bits left to clock
    logic [1:0]          soSync_reg;   // Two-stage synchroniser for serial out
    logic [WAIT_W-1:0]   waitValue;    // Load value for the timer
    logic                waitLoad;     // Timer load strobe
    logic                waitDone;     // Timer expired
    logic [15:0]         idleCount_reg;// Long idle counter, above timer width

    // Settling and pin-width waits
    wait_timer #(.W(WAIT_W)) uWait (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .load      (waitLoad),
        .loadValue (waitValue),
        .done      (waitDone)
    );

    assign cmdReady = (state_reg == S_IDLE);

    // Serial out comes from another chip: two flops before use
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            soSync_reg <= 2'h0;
        end else begin
            soSync_reg <= {soSync_reg[0], serialDataOut};
        end
    end

    // Idle counter for the quiet period before any update
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            idleCount_reg <= 16'h0;
        end else if (state_reg == S_IDLE && cmdValid) begin
            idleCount_reg <= 16'(IDLE_CYCLES);
        end else if (idleCount_reg != 16'h0) begin
            idleCount_reg <= idleCount_reg - 16'h1;
        end
    end

    // Timer load points and their lengths
    always_comb begin
        waitLoad  = 1'b0;
        waitValue = '0;
        case (state_reg)
            S_PSET: begin
                waitLoad  = 1'b1;
                waitValue = WAIT_W'(PAR_SETTLE_CYC);
            end
            S_EN_LO, S_SDROP: begin
                waitLoad  = 1'b1;
                waitValue = WAIT_W'(EN_SETTLE_CYC);
            end
            S_EN_HI: begin
                waitLoad  = (waitDone && op_reg != CMD_PAR_LATCHED);
                waitValue = WAIT_W'(EN_FIRST_BIT_CYC);
            end
            S_CLK_LO, S_CLK_HI: begin
                waitLoad  = waitDone;
                waitValue = WAIT_W'(SETUP_CYC);
            end
            default: begin
                waitLoad  = (state_reg == S_QUIET && idleCount_reg == 16'h0);
                waitValue = WAIT_W'(SETUP_CYC);
            end
        endcase
    end

    // Main sequencer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg    <= S_IDLE;
            op_reg       <= CMD_PAR_TRANSPARENT;
            code_reg     <= '0;
            read_reg     <= '0;
            bitCount_reg <= 4'h0;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    if (cmdValid) begin
                        op_reg   <= cmd_t'(cmdOp);
                        code_reg <= cmdCode;
                        state_reg <= S_QUIET;
                    end
                end
                S_QUIET: begin
                    // Delayed input held idle for the full delay first
                    if (idleCount_reg == 16'h0) begin
                        state_reg <= (op_reg == CMD_PAR_TRANSPARENT) ? S_PSET : S_EN_HI;
                    end
                end
                S_PSET: state_reg <= S_PSETTL;
                S_PSETTL: begin
                    if (waitDone) begin
                        state_reg <= S_DONE;
                    end
                end
                S_EN_HI: begin
                    // Enable high at least its minimum width
                    if (waitDone) begin
                        bitCount_reg <= 4'(CODE_W);
                        state_reg <= (op_reg == CMD_PAR_LATCHED) ? S_EN_LO : S_SFIRST;
                    end
                end
                S_SFIRST: begin
                    // Bit 7 shows up before any clock edge
                    if (waitDone) begin
                        state_reg <= S_CLK_LO;
                    end
                end
                S_CLK_LO: begin
                    if (waitDone) begin
                        // Sample serial out before the rising edge moves it
                        read_reg  <= {read_reg[CODE_W-2:0], soSync_reg[1]};
                        state_reg <= S_CLK_HI;
                    end
                end
                S_CLK_HI: begin
                    if (waitDone) begin
                        code_reg     <= {code_reg[CODE_W-2:0], 1'b0};
                        bitCount_reg <= bitCount_reg - 4'h1;
                        state_reg    <= (bitCount_reg == 4'h1) ? S_SDROP : S_CLK_LO;
                    end
                end
                S_EN_LO, S_SDROP: state_reg <= S_PSETTL;
                S_DONE:  state_reg <= S_IDLE;
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // Pin drive from state; enable falls on leaving EN_HI for a latched op or the clock phase, or in QUIET after a transparent op
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            loadMethodSelect <= 1'b1;
            addressEnable    <= 1'b0;
            parallelStepBits <= '0;
            serialShiftClock <= 1'b0;
            serialDataIn     <= 1'b0;
        end else begin
            // Mode pin moves only with enable low, so a falling enable never
            // races a mode change and latches under the wrong mode
            loadMethodSelect <= (state_reg == S_IDLE || addressEnable) ? loadMethodSelect
                              : !op_reg[1];
            // Bits move only while enable rises or stays high; a falling
            // enable then always latches the code that was in force
            if (state_reg == S_PSET ||
                (state_reg == S_EN_HI && op_reg == CMD_PAR_LATCHED)) begin
                parallelStepBits <= code_reg;
            end
            addressEnable <= (state_reg == S_EN_HI) || (state_reg == S_SFIRST) ||
                             (state_reg == S_CLK_LO) || (state_reg == S_CLK_HI) ||
                             (state_reg == S_PSET && op_reg == CMD_PAR_TRANSPARENT) ||
                             (state_reg == S_PSETTL && op_reg == CMD_PAR_TRANSPARENT) ||
                             (addressEnable && op_reg == CMD_PAR_TRANSPARENT &&
                              state_reg != S_QUIET);
            serialShiftClock <= (state_reg == S_CLK_HI);
            serialDataIn     <= code_reg[CODE_W-1];
        end
    end

    // Answer: read code for serial ops, echoed code otherwise
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rspValid <= 1'b0;
            rspCode  <= '0;
        end else begin
            rspValid <= (state_reg == S_DONE);
            if (state_reg == S_DONE) begin
                rspCode <= op_reg[1] ? read_reg : parallelStepBits;
            end
        end
    end

    assign signalIdle = (state_reg != S_IDLE);
endmodule : delay_step_program_port

// *** src/delay_prog_pkg.sv ***
package delay_prog_pkg;
    // Width of the delay step code
    localparam int CODE_W           = 8;
    // Host clock period in ns
    localparam int CLK_PERIOD_NS    = 20;
    // Device timing figures in ns
    localparam int PAR_SETTLE_NS    = 40;   // parallel_settle_time, longest
    localparam int EN_SETTLE_NS     = 45;   // enable_settle_time, longest
    localparam int EN_FIRST_BIT_NS  = 20;   // enable_to_first_bit_time, longest
    localparam int SETUP_NS         = 10;   // setup, enable width, clock width
    // Waits the host must give, rounded up to whole cycles
    localparam int PAR_SETTLE_CYC   = (PAR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EN_SETTLE_CYC    = (EN_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EN_FIRST_BIT_CYC = (EN_FIRST_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CYC        = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Idle time before an update: worst-case full delay, in ns
    localparam int IDLE_NS          = 1300;
    localparam int IDLE_CYC         = (IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Counter width for the settle and pin-width timer waits
    localparam int WAIT_W           = 8;
    // Commands
    typedef enum logic [1:0] {
        CMD_PAR_TRANSPARENT = 2'b00,
        CMD_PAR_LATCHED     = 2'b01,
        CMD_SERIAL_WRITE    = 2'b10,
        CMD_SERIAL_READ     = 2'b11
    } cmd_t;
endpackage : delay_prog_pkg

// *** src/wait_timer.sv ***
`timescale 1ns/1ns
// Loadable down counter; done is high while count is zero
module wait_timer
    import delay_prog_pkg::*;
#(
    parameter int W = WAIT_W
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic         load,
    input  wire logic [W-1:0] loadValue,
    output logic              done
);
    logic [W-1:0] count_reg;  // Remaining cycles

    // Count down to zero and hold there
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= '0;
        end else if (load) begin
            count_reg <= loadValue;
        end else if (count_reg != '0) begin
            count_reg <= count_reg - W'(1);
        end
    end

    assign done = (count_reg == '0);
endmodule : wait_timer

// *** dv/delay_step_program_port_sva.sv ***
`timescale 1ns/1ns
// Pin timing checks for the delay program port
module delay_step_program_port_chk
    import delay_prog_pkg::*;
(
    input wire logic              ref_clk,
    input wire logic              rst_n,
    input wire logic              cmdValid,
    input wire logic              cmdReady,
    input wire logic [1:0]        cmdOp,
    input wire logic [CODE_W-1:0] cmdCode,
    input wire logic              rspValid,
    input wire logic [CODE_W-1:0] rspCode,
    input wire logic              loadMethodSelect,
    input wire logic              addressEnable,
    input wire logic [CODE_W-1:0] parallelStepBits,
    input wire logic              serialShiftClock,
    input wire logic              serialDataIn,
    input wire logic              serialDataOut,
    input wire logic              signalIdle
);
    logic [3:0] clkCount_reg;  // Shift clock rises in this window
    // Counter restarts at each window so stray clocks are caught
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) clkCount_reg <= 4'h0;
        else if ($rose(addressEnable)) clkCount_reg <= 4'h0;
        else if ($rose(serialShiftClock)) clkCount_reg <= clkCount_reg + 4'h1;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Device needs time to show bit 7 before the first clock
    sequence s_clockQuiet;
        !serialShiftClock ##1 !serialShiftClock;
    endsequence
    a_clock_in_window: assert property ($rose(serialShiftClock) |-> addressEnable && !loadMethodSelect)
        else $error("shift clock outside serial window");
    a_data_held: assert property ($rose(serialShiftClock) |-> $stable(serialDataIn))
        else $error("serial data moved at clock rise");
    a_first_bit_wait: assert property ($rose(addressEnable) && !loadMethodSelect |-> s_clockQuiet)
        else $error("shift clock too soon after enable");
    a_eight_per_window: assert property ($fell(addressEnable) && !loadMethodSelect |-> clkCount_reg == 4'h8)
        else $error("window did not hold eight clocks");
    a_latch_bits_held: assert property ($fell(addressEnable) && loadMethodSelect |-> $stable(parallelStepBits))
        else $error("parallel bits moved at enable fall");
    a_settle_before_rsp: assert property (rspValid && !loadMethodSelect |-> !$past(addressEnable) && !$past(addressEnable, 2))
        else $error("answer before enable settle");
    a_idle_while_busy: assert property ($rose(addressEnable) || $changed(parallelStepBits) |-> signalIdle && $past(signalIdle, 2))
        else $error("idle request missing while busy");
    a_transparent_bits: assert property (rspValid && loadMethodSelect && addressEnable |-> parallelStepBits == rspCode)
        else $error("transparent bits differ from code");
endmodule : delay_step_program_port_chk

bind delay_step_program_port delay_step_program_port_chk chk (.ref_clk, .rst_n, .cmdValid, .cmdReady,
    .cmdOp, .cmdCode, .rspValid, .rspCode, .loadMethodSelect, .addressEnable, .parallelStepBits,
    .serialShiftClock, .serialDataIn, .serialDataOut, .signalIdle);

// *** dv/delay_line_model.sv ***
`timescale 1ns/1ns
// Behavioural programming logic of the delay line; it has no clock
module delay_line_model (
    input  wire logic       modeSel,
    input  wire logic       enable,
    input  wire logic [7:0] stepBits,
    input  wire logic       shiftClock,
    input  wire logic       dataIn,
    output logic            dataOut,
    output logic [7:0]      activeCode
);
    logic [7:0] inputReg;  // Input shift register
    logic [7:0] heldCode;  // Code in force after enable falls
    logic [7:0] passBits;  // Transparent bits after settling
    // Powers up at step zero
    initial begin
        inputReg = 8'h00;
        heldCode = 8'h00;
    end
    // One bit per clock rise, MSB first; old contents leave at the top
    always @(posedge shiftClock) if (!modeSel && enable) inputReg <= {inputReg[6:0], dataIn};
    // Enable fall latches; late update so early reads see the old code
    always @(negedge enable) begin
        if (modeSel) begin
            heldCode <= #40 stepBits;
            inputReg <= stepBits;
        end else begin
            heldCode <= #40 inputReg;
        end
    end
    assign #35 passBits = stepBits;
    // Transparent mode passes bits through as a binary step
    assign activeCode = (modeSel && enable) ? passBits : heldCode;
    // Released pin shows the inverse so a stale bit never looks valid
    assign dataOut = (!modeSel && enable) ? inputReg[7] : ~inputReg[7];
endmodule : delay_line_model

// *** dv/testbench.sv ***
`timescale 1ns/1ns
// Drives commands, checks answers and the model's code through a queue
module testbench;
    import delay_prog_pkg::*;
    logic        ref_clk, rst_n, cmdValid, cmdReady, rspValid, signalIdle;
    logic        loadMethodSelect, addressEnable, serialShiftClock, serialDataIn, serialDataOut;
    logic [1:0]  cmdOp;
    logic [7:0]  cmdCode, rspCode, parallelStepBits, activeCode, lastCode;
    logic [15:0] notes[$];  // Expected answer and device code
    int          n_errors, comparisons, seed;
    // Short idle hold keeps the run brief
    delay_step_program_port #(.IDLE_CYCLES(2)) uut (.ref_clk, .rst_n, .cmdValid, .cmdReady,
        .cmdOp, .cmdCode, .rspValid, .rspCode, .loadMethodSelect, .addressEnable,
        .parallelStepBits, .serialShiftClock, .serialDataIn, .serialDataOut, .signalIdle);
    delay_line_model device (.modeSel(loadMethodSelect), .enable(addressEnable),
        .stepBits(parallelStepBits), .shiftClock(serialShiftClock), .dataIn(serialDataIn),
        .dataOut(serialDataOut), .activeCode(activeCode));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task conclude;
        if (n_errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude
    task check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // Holds the request until an edge sees ready, then lets one edge pass
    task issue(input logic [1:0] op, input logic [7:0] code);
        cmdOp <= op;
        cmdCode <= code;
        cmdValid <= 1'b1;
        @(posedge ref_clk);
        while (cmdReady !== 1'b1) @(posedge ref_clk);
        cmdValid <= 1'b0;
        // Serial ops answer with the bits read back, parallel ops with the code
        notes.push_back({op[1] ? lastCode : code, code});
        lastCode = code;
        @(posedge ref_clk);
    endtask : issue
    // Each answer is matched with the oldest note
    always @(posedge ref_clk) begin
        if (rspValid === 1'b1 && notes.size() > 0) begin
            check(rspCode, notes[0][15:8]);
            check(activeCode, notes[0][7:0]);
            void'(notes.pop_front());
        end
    end
    initial begin
        #100000;
        n_errors++;
        conclude();
    end
    initial begin
        seed = 32'h31b5;
        n_errors = 0;
        comparisons = 0;
        lastCode = 8'h00;
        rst_n = 1'b0;
        cmdValid = 1'b0;
        cmdOp = 2'b00;
        cmdCode = 8'h00;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        issue(2'b11, 8'h5a);
        for (int i = 0; i < 12; i++) issue(i[1:0], 8'($random(seed)));
        issue(2'b11, 8'hff);
        issue(2'b11, 8'h00);
        for (int k = 0; k < 2000 && notes.size() != 0; k++) @(posedge ref_clk);
        if (notes.size() != 0) n_errors++;
        conclude();
    end
endmodule : testbench
